// ---- rtl/spicc_pkg.sv ----
// Purpose: Shared constants and types of the serial port control block
// Assumes: APB offsets are byte addresses, one 32-bit word per register
// Notes: Bit positions refer to the control words held by the top module
package spicc_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] A_CTRL0 = 8'h00;
  localparam logic [7:0] A_CTRL1 = 8'h04;
  localparam logic [7:0] A_DATA = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0C;
  localparam logic [7:0] A_MASK = 8'h14;
  localparam logic [7:0] A_IRQ = 8'h18;
  localparam logic [31:0] CTRL0_RST = 32'h0;
  localparam logic [31:0] CTRL1_RST = 32'h0;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int FS_LO = 0;
  localparam int SCR_LO = 8;
  localparam int FRF_LO = 21;
  localparam int EN_B = 1;
  localparam int ROLE_B = 2;
  localparam int GATE_B = 3;
  localparam int RXORD_LO = 4;
  localparam int MICROWIRE_WAIT_ENABLE_B = 6;
  localparam int RXTHR_LO = 7;
  localparam int TXTHR_LO = 10;
  localparam int WAIT_LO = 14;
  localparam int TXORD_LO = 18;
  localparam int DLY_B = 21;
  // ----------------------------------------
  // Encodings and counts
  // ----------------------------------------
  localparam logic [4:0] FS_MIN = 5'h03;
  localparam logic [1:0] FRF_SPI = 2'h0;
  localparam logic [1:0] FRF_MW = 2'h2;
  localparam int DELAY_CYC = 2;
  localparam logic [2:0] SYNC_RST = 3'h2;
  localparam int IRQ_RX = 0;
  localparam int IRQ_TX = 1;
  localparam int IRQ_OVR = 2;
  localparam int IRQ_DONE = 3;

  typedef enum logic [1:0] {SPICC_IDLE, SPICC_XFER, SPICC_WAIT} spicc_st_t;

  // Reserved threshold codes fall back to one element
  function automatic logic [3:0] spicc_lvl(input logic [2:0] code);
    unique case (code)
      3'h1: spicc_lvl = 4'h4;
      3'h2: spicc_lvl = 4'h8;
      default: spicc_lvl = 4'h1;
    endcase
  endfunction : spicc_lvl
endpackage : spicc_pkg

// ---- rtl/spicc_pin_if.sv ----
// Purpose: Synchronised link levels passed from the pin stage to the engine
// Assumes: All members are on the pclk domain
// Notes: dly_en flows back from the control word
`timescale 1ns/10ps
interface spicc_pin_if;
  logic sclk;
  logic ss_n;
  logic sdi;
  logic dly_en;
  modport src (output sclk, output ss_n, output sdi, input dly_en);
  modport dst (input sclk, input ss_n, input sdi, output dly_en);
endinterface : spicc_pin_if

// ---- rtl/spicc_sync.sv ----
// Purpose: Two-flop synchronisers for link pins and the optional input delay
// Assumes: Raw pins are asynchronous to pclk
// Notes: The delay taps the synchronised data, never the first flop
`timescale 1ns/10ps
module spicc_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sclk_raw,
  input wire logic ss_n_raw,
  input wire logic sdi_raw,
  spicc_pin_if.src lk
);
  typedef struct packed {
    logic [2:0] m;
    logic [2:0] s;
    logic [1:0] dl;
  } spicc_sync_t;
  spicc_sync_t q;
  spicc_sync_t d;

  always_comb begin
    d = q;
    d.m = {sclk_raw, ss_n_raw, sdi_raw};
    d.s = q.m;
    d.dl = {q.dl[0], q.s[0]};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{m: spicc_pkg::SYNC_RST, s: spicc_pkg::SYNC_RST, dl: 2'h0};
    end else begin
      q <= d;
    end
  end

  assign lk.sclk = q.s[2];
  assign lk.ss_n = q.s[1];
  assign lk.sdi = lk.dly_en ? q.dl[1] : q.s[0];

  property p_delay;
    @(posedge pclk) disable iff (!presetn)
    lk.dly_en |-> lk.sdi == $past(q.s[0], 2);
  endproperty
  a_delay: assert property (p_delay) else $error("input delay is not two cycles");
endmodule : spicc_sync

// ---- rtl/spicc_order.sv ----
// Purpose: Byte and bit ordering of one right-justified element
// Assumes: Input bits above the element size are zero
// Notes: Each mapping is its own inverse, so transmit and receive share it
`timescale 1ns/10ps
module spicc_order (
  input wire logic [31:0] din,
  input wire logic [5:0] size,
  input wire logic [1:0] code,
  output logic [31:0] dout
);
  logic [31:0] frev;
  logic [31:0] full;
  logic [31:0] brev;
  logic [31:0] fbrev;

  genvar i;
  generate
    for (i = 0; i < 32; i++) begin : g_bit
      assign frev[i] = din[31 - i];
      assign brev[i] = din[(i / 8) * 8 + 7 - (i % 8)];
      assign fbrev[i] = full[(i / 8) * 8 + 7 - (i % 8)];
    end
  endgenerate

  // Whole-element reversal is byte reversal plus bit reversal in each byte
  assign full = frev >> (6'd32 - size);

  always_comb begin
    unique case (code)
      2'h0: dout = din;
      2'h1: dout = fbrev;
      2'h2: dout = brev;
      default: dout = full;
    endcase
  end
endmodule : spicc_order

// ---- rtl/spicc_top.sv ----
// Purpose: Serial port with SPI or MicroWire framing, APB registers, FIFOs
// Assumes: Clock mode 0 (idle low, sample on rise, shift on fall)
// Notes: Master bit timing is (scr+1) pclk cycles per half period
// Operation
// - Role bit 0 makes the port master, 1 makes it slave.
// - Slave with output gate set never drives MISO.
// - Gate lets one ungated slave answer a broadcast from the master.
// - Receive ordering field selects byte and bit order of received elements.
// - Transmit ordering field selects the same four orders for sent elements.
// - MicroWire wait bit adds one wait state between frames.
// - Receive request rises at 1, 4 or 8 held elements.
// - Transmit request rises at 1, 4 or 8 held elements.
// - SPI wait field sets wait states between consecutive frames.
// - Input delay bit delays received data by two clocks.
// - Every control field resets to zero.
// - Frame size is size field plus one, 4 to 32 bits.
// - Format field 0 selects SPI framing, 2 selects MicroWire.
//
// Register access over APB was left to the implementer.
`timescale 1ns/10ps
module spicc_top #(
  parameter int DEPTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe,
  input wire logic ss_n_i,
  output logic ss_n_o,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe,
  output logic irq
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  typedef struct packed {
    spicc_pkg::spicc_st_t st;
    logic [31:0] c0;
    logic [31:0] c1;
    logic [DEPTH-1:0][31:0] txf;
    logic [DEPTH-1:0][31:0] rxf;
    logic [AW-1:0] twp;
    logic [AW-1:0] trp;
    logic [AW-1:0] rwp;
    logic [AW-1:0] rrp;
    logic [CW-1:0] tcnt;
    logic [CW-1:0] rcnt;
    logic [31:0] sh;
    logic [31:0] rsh;
    logic [5:0] bits;
    logic [7:0] div;
    logic [4:0] wcnt;
    logic [3:0] mask;
    logic [3:0] istat;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sclk;
    logic sclk_d;
    logic sclk_oe;
    logic ss_n;
    logic mosi_oe;
    logic miso_oe;
    logic irq;
  } spicc_state_t;

  spicc_state_t q;
  spicc_state_t d;
  spicc_pin_if lk ();

  logic en, role, gate, mw, setup, acc, wr, rd, hit, clr;
  logic tick, rise, fall, tpush, tpop, rpush, rpop, ovr, done_m;
  logic [5:0] n;
  logic [31:0] msk, txm, rxm, rnx, ld_sh;
  logic [3:0] rlvl, tlvl, ev;

  // ----------------------------------------
  // Pin stage and ordering
  // ----------------------------------------
  spicc_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .sclk_raw(sclk_i),
    .ss_n_raw(ss_n_i),
    .sdi_raw(q.c1[spicc_pkg::ROLE_B] ? mosi_i : miso_i),
    .lk(lk.src)
  );
  assign lk.dly_en = q.c1[spicc_pkg::DLY_B];

  spicc_order u_txo (
    .din(q.txf[q.trp] & msk),
    .size(n),
    .code(q.c1[spicc_pkg::TXORD_LO +: 2]),
    .dout(txm)
  );

  spicc_order u_rxo (
    .din(rnx & msk),
    .size(n),
    .code(q.c1[spicc_pkg::RXORD_LO +: 2]),
    .dout(rxm)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    d = q;
    en = q.c1[spicc_pkg::EN_B];
    role = q.c1[spicc_pkg::ROLE_B];
    gate = q.c1[spicc_pkg::GATE_B];
    mw = q.c0[spicc_pkg::FRF_LO +: 2] == spicc_pkg::FRF_MW;
    // Reserved small sizes run as 4 bits rather than a degenerate frame
    n = (q.c0[spicc_pkg::FS_LO +: 5] < spicc_pkg::FS_MIN) ? 6'h04
      : {1'b0, q.c0[spicc_pkg::FS_LO +: 5]} + 6'h01;
    msk = 32'hFFFFFFFF >> (6'd32 - n);
    ld_sh = txm << (6'd32 - n);
    rnx = {q.rsh[30:0], lk.sdi};
    rlvl = spicc_pkg::spicc_lvl(q.c1[spicc_pkg::RXTHR_LO +: 3]);
    tlvl = spicc_pkg::spicc_lvl(q.c1[spicc_pkg::TXTHR_LO +: 3]);
    setup = psel && !penable;
    acc = psel && penable && q.pready;
    wr = acc && pwrite;
    rd = acc && !pwrite;
    hit = paddr inside {spicc_pkg::A_CTRL0, spicc_pkg::A_CTRL1, spicc_pkg::A_DATA,
                        spicc_pkg::A_STAT, spicc_pkg::A_MASK, spicc_pkg::A_IRQ};
    tpush = 1'b0;
    tpop = 1'b0;
    rpush = 1'b0;
    rpop = 1'b0;
    clr = 1'b0;
    done_m = 1'b0;
    d.sclk_d = lk.sclk;
    // APB: one access cycle, data prepared during setup
    d.pready = setup;
    d.pslverr = setup && !hit;
    if (setup && !pwrite) begin
      unique case (paddr)
        spicc_pkg::A_CTRL0: d.prdata = q.c0;
        spicc_pkg::A_CTRL1: d.prdata = q.c1;
        spicc_pkg::A_DATA: d.prdata = q.rxf[q.rrp];
        spicc_pkg::A_STAT: d.prdata = {27'h0, q.st != spicc_pkg::SPICC_IDLE || q.tcnt != '0,
                                       q.rcnt == CW'(DEPTH), q.rcnt != '0,
                                       q.tcnt != CW'(DEPTH), q.tcnt == '0};
        spicc_pkg::A_MASK: d.prdata = {28'h0, q.mask};
        spicc_pkg::A_IRQ: d.prdata = {28'h0, q.istat};
        default: d.prdata = 32'h0;
      endcase
    end
    if (wr) begin
      unique case (paddr)
        spicc_pkg::A_CTRL0: d.c0 = pwdata;
        spicc_pkg::A_CTRL1: d.c1 = pwdata;
        spicc_pkg::A_DATA: tpush = q.tcnt != CW'(DEPTH);
        spicc_pkg::A_MASK: d.mask = pwdata[3:0];
        default: ;
      endcase
    end
    if (rd) begin
      rpop = (paddr == spicc_pkg::A_DATA) && q.rcnt != '0;
      clr = paddr == spicc_pkg::A_IRQ;
    end
    // Edge events: master from its divider, slave from the synced clock
    tick = q.div == q.c0[spicc_pkg::SCR_LO +: 8];
    rise = role ? (lk.sclk && !q.sclk_d) : (tick && !q.sclk);
    fall = role ? (!lk.sclk && q.sclk_d) : (tick && q.sclk);
    if (q.st != spicc_pkg::SPICC_IDLE) begin
      d.div = tick ? 8'h00 : q.div + 8'h01;
    end
    if (!en) begin
      d.st = spicc_pkg::SPICC_IDLE;
      d.ss_n = 1'b1;
      d.sclk = 1'b0;
    end else begin
      unique case (q.st)
        spicc_pkg::SPICC_IDLE: begin
          if (role ? !lk.ss_n : q.tcnt != '0) begin
            tpop = q.tcnt != '0;
            // An empty slave shifts out zeros instead of stalling the master
            d.sh = tpop ? ld_sh : 32'h0;
            d.bits = n;
            d.div = 8'h00;
            d.ss_n = role;
            d.st = spicc_pkg::SPICC_XFER;
          end
        end
        spicc_pkg::SPICC_XFER: begin
          if (role && lk.ss_n) begin
            d.st = spicc_pkg::SPICC_IDLE;
          end else begin
            if (!role && tick) begin
              d.sclk = !q.sclk;
            end
            if (rise && q.bits != 6'h00) begin
              d.rsh = rnx;
              d.bits = q.bits - 6'h01;
              rpush = q.bits == 6'h01;
            end
            if (fall) begin
              if (q.bits == 6'h00) begin
                done_m = !role;
                d.st = role ? spicc_pkg::SPICC_IDLE : spicc_pkg::SPICC_WAIT;
                d.wcnt = mw ? {4'h0, q.c1[spicc_pkg::MICROWIRE_WAIT_ENABLE_B]}
                  : {1'b0, q.c1[spicc_pkg::WAIT_LO +: 4]};
              end else begin
                d.sh = q.sh << 1;
              end
            end
          end
        end
        default: begin
          if (tick) begin
            if (q.wcnt == 5'h00) begin
              d.ss_n = 1'b1;
              d.st = spicc_pkg::SPICC_IDLE;
            end else begin
              d.wcnt = q.wcnt - 5'h01;
            end
          end
        end
      endcase
    end
    // ----------------------------------------
    // FIFOs
    // ----------------------------------------
    ovr = rpush && q.rcnt == CW'(DEPTH) && !rpop;
    if (tpush) begin
      d.txf[q.twp] = pwdata;
      d.twp = q.twp + AW'(1);
    end
    if (tpop) begin
      d.trp = q.trp + AW'(1);
    end
    if (rpush && !ovr) begin
      d.rxf[q.rwp] = rxm;
      d.rwp = q.rwp + AW'(1);
    end
    if (rpop) begin
      d.rrp = q.rrp + AW'(1);
    end
    d.tcnt = q.tcnt + CW'(tpush) - CW'(tpop);
    d.rcnt = q.rcnt + CW'(rpush && !ovr) - CW'(rpop);
    // ----------------------------------------
    // Interrupts: set wins over read-clear
    // ----------------------------------------
    ev = '0;
    ev[spicc_pkg::IRQ_RX] = q.rcnt >= CW'(rlvl);
    ev[spicc_pkg::IRQ_TX] = q.tcnt >= CW'(tlvl);
    ev[spicc_pkg::IRQ_OVR] = ovr;
    ev[spicc_pkg::IRQ_DONE] = done_m || (rpush && role);
    d.istat = (clr ? 4'h0 : q.istat) | ev;
    d.irq = |(d.istat & d.mask);
    // ----------------------------------------
    // Pin drivers
    // ----------------------------------------
    d.sclk_oe = en && !role;
    d.mosi_oe = en && !role;
    d.miso_oe = en && role && !gate && !lk.ss_n;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.st <= spicc_pkg::SPICC_IDLE;
      q.c0 <= spicc_pkg::CTRL0_RST;
      q.c1 <= spicc_pkg::CTRL1_RST;
      q.ss_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign sclk_o = q.sclk;
  assign sclk_oe = q.sclk_oe;
  assign ss_n_o = q.ss_n;
  assign mosi_o = q.sh[31];
  assign mosi_oe = q.mosi_oe;
  assign miso_o = q.sh[31];
  assign miso_oe = q.miso_oe;
  assign irq = q.irq;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_load;
    q.st == spicc_pkg::SPICC_IDLE ##1 q.st == spicc_pkg::SPICC_XFER;
  endsequence
  sequence s_mend;
    done_m ##1 q.st == spicc_pkg::SPICC_WAIT;
  endsequence

  property p_off;
    !en |=> q.st == spicc_pkg::SPICC_IDLE && q.ss_n;
  endproperty
  a_off: assert property (p_off) else $error("disabled port still framing");
  property p_role;
    en && !role |=> q.sclk_oe && q.mosi_oe && !q.miso_oe;
  endproperty
  a_role: assert property (p_role) else $error("master does not drive clock");
  property p_gate;
    gate |=> !q.miso_oe;
  endproperty
  a_gate: assert property (p_gate) else $error("gated slave drives MISO");
  property p_one;
    q.miso_oe |-> $past(role && !gate);
  endproperty
  a_one: assert property (p_one) else $error("MISO driven without slave role");
  property p_txord;
    !role && q.tcnt != '0 ##0 s_load |-> q.sh == $past(ld_sh) && q.bits == $past(n);
  endproperty
  a_txord: assert property (p_txord) else $error("shift load does not match ordering");
  property p_rxord;
    rpush && !ovr |=> q.rxf[$past(q.rwp)] == $past(rxm);
  endproperty
  a_rxord: assert property (p_rxord) else $error("received element misordered");
  property p_mw;
    mw ##0 s_mend |-> q.wcnt == {4'h0, $past(q.c1[spicc_pkg::MICROWIRE_WAIT_ENABLE_B])};
  endproperty
  a_mw: assert property (p_mw) else $error("MicroWire wait count wrong");
  property p_spiw;
    !mw ##0 s_mend |-> q.wcnt == {1'b0, $past(q.c1[spicc_pkg::WAIT_LO +: 4])};
  endproperty
  a_spiw: assert property (p_spiw) else $error("SPI wait count wrong");
  property p_rthr;
    q.rcnt >= CW'(rlvl) |=> q.istat[spicc_pkg::IRQ_RX];
  endproperty
  a_rthr: assert property (p_rthr) else $error("receive level request missing");
  property p_tthr;
    q.tcnt >= CW'(tlvl) |=> q.istat[spicc_pkg::IRQ_TX];
  endproperty
  a_tthr: assert property (p_tthr) else $error("transmit level request missing");
endmodule : spicc_top

// ---- tb/spicc_peer.sv ----
// Purpose: Far-side link peer: slave for the master role, master for the slave role
// Assumes: Clock mode 0, MSB of the word first on the wire
// Notes: Link clock stands low between frames; 48 ns period
`timescale 1ns/10ps
module spicc_peer (
  input wire logic sclk_o,
  input wire logic ss_n_o,
  input wire logic mosi_o,
  input wire logic miso_o,
  output logic sclk_i,
  output logic ss_n_i,
  output logic mosi_i,
  output logic miso_i
);
  logic [31:0] tx_word;
  logic [31:0] rx_word;
  int size;
  int cnt;
  initial begin
    sclk_i = 0;
    ss_n_i = 1;
    mosi_i = 0;
    miso_i = 0;
    tx_word = 0;
    rx_word = 0;
    size = 16;
    cnt = 0;
  end
  always @(negedge ss_n_o) begin
    cnt = size - 1;
    miso_i = tx_word[cnt];
    rx_word = 0;
  end
  always @(posedge sclk_o) if (ss_n_o === 1'b0) rx_word = {rx_word[30:0], mosi_o};
  always @(negedge sclk_o) if (ss_n_o === 1'b0 && cnt > 0) begin
    cnt--;
    miso_i = tx_word[cnt];
  end
  // Undriven line has no pull, so show a changed level rather than the last bit
  always @(posedge ss_n_o) miso_i = ~miso_i;
  task xfer(input int n, input logic [31:0] val, output logic [31:0] got);
    got = 0;
    mosi_i = val[n-1];
    ss_n_i = 0;
    #48;
    for (int i = n - 1; i >= 0; i--) begin
      sclk_i = 1;
      got = {got[30:0], miso_o};
      #24;
      sclk_i = 0;
      if (i > 0) mosi_i = val[i-1];
      #24;
    end
    ss_n_i = 1;
    mosi_i = ~mosi_i;
  endtask : xfer
endmodule : spicc_peer

// ---- tb/spi_control_config_test.sv ----
// Purpose: Self-checking bench of the serial port control word
// Assumes: Half period of five pclk cycles in master role
// Notes: Register traffic over APB, link traffic through the peer
`timescale 1ns/10ps
module spi_control_config_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, oe_seen;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, got;
  logic sclk_i, sclk_o, sclk_oe, ss_n_i, ss_n_o, mosi_i, mosi_o, mosi_oe, miso_i, miso_o, miso_oe, irq;
  int n_fail, cmp_count, len0, len, k, j, lvl, t;
  localparam logic [31:0] EN = 32'h1 << spicc_pkg::EN_B;
  localparam logic [31:0] MW = 32'h1 << spicc_pkg::MICROWIRE_WAIT_ENABLE_B;
  localparam logic [7:0] DR = spicc_pkg::A_DATA;
  localparam logic [7:0] C1 = spicc_pkg::A_CTRL1;
  localparam logic [7:0] IQ = spicc_pkg::A_IRQ;
  spicc_top spicc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk_i(sclk_i),
    .sclk_o(sclk_o), .sclk_oe(sclk_oe), .ss_n_i(ss_n_i), .ss_n_o(ss_n_o), .mosi_i(mosi_i), .mosi_o(mosi_o),
    .mosi_oe(mosi_oe), .miso_i(miso_i), .miso_o(miso_o), .miso_oe(miso_oe), .irq(irq));
  // Undriven data lines have no pull, so the peer sees the inverse of the driven level
  spicc_peer spicc_peer_i (.sclk_o(sclk_o), .ss_n_o(ss_n_o), .mosi_o(mosi_oe ? mosi_o : ~mosi_o),
    .miso_o(miso_oe ? miso_o : ~miso_o), .sclk_i(sclk_i), .ss_n_i(ss_n_i), .mosi_i(mosi_i), .miso_i(miso_i));
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) if (miso_oe === 1'b1) oe_seen <= 1'b1;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task wrap_up;
    $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task hang;
    n_fail++;
    $display("MISMATCH t=%0t wait ran out", $time);
    wrap_up;
  endtask : hang
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) hang;
    q = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd
  // Counts pclk cycles with the select low
  task frame;
    t = 0;
    while (ss_n_o !== 1'b0 && t < 100) begin
      @(posedge pclk);
      t++;
    end
    len = 0;
    while (ss_n_o === 1'b0 && len < 1000) begin
      @(posedge pclk);
      len++;
    end
    if (t >= 100 || len >= 1000) hang;
    repeat (4) @(posedge pclk);
  endtask : frame
  function automatic logic [31:0] ord(input logic [15:0] v, input logic [1:0] c);
    logic [15:0] r;
    for (int i = 0; i < 16; i++) r[i] = v[15-i];
    case (c)
      2'h0: ord = {16'h0, v};
      2'h1: ord = {16'h0, v[7:0], v[15:8]};
      2'h2: ord = {16'h0, r[7:0], r[15:8]};
      default: ord = {16'h0, r};
    endcase
  endfunction : ord
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    n_fail = 0; cmp_count = 0; oe_seen = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1;
    check(32'({sclk_oe, ss_n_o, miso_oe, irq}), 32'h4);
    rd(C1); check(q, 32'h0);
    rd(spicc_pkg::A_STAT); check(q, 32'h3);
    rd(8'h40); check(32'({err, q[0]}), 32'h2);
    wr(C1, 32'h002F_DFFE); rd(C1); check(q, 32'h002F_DFFE);
    wr(C1, 32'h0);
    wr(spicc_pkg::A_CTRL0, 32'h0000_040F); // 16-bit SPI frames
    rd(spicc_pkg::A_CTRL0); check(q, 32'h0000_040F);
    wr(DR, 32'h1234);
    repeat (60) @(posedge pclk);
    check(32'({ss_n_o, sclk_oe}), 32'h2);
    spicc_peer_i.tx_word = 32'hA5C3;
    for (k = 0; k < 4; k++) begin
      wr(C1, EN | 32'(k) << spicc_pkg::RXORD_LO | 32'(k) << spicc_pkg::TXORD_LO);
      if (k > 0) wr(DR, 32'h1234);
      frame;
      check(spicc_peer_i.rx_word, ord(16'h1234, 2'(k)));
      check(32'({sclk_oe, mosi_oe}), 32'h3);
      rd(DR); check(q, ord(16'hA5C3, 2'(k)));
    end
    for (k = 0; k < 4; k++) begin
      wr(spicc_pkg::A_CTRL0, (k < 2) ? 32'h040F : 32'h0040_040F);
      wr(C1, EN | ((k == 1) ? 32'h3 << spicc_pkg::WAIT_LO : 32'h0) | ((k == 3) ? MW : 32'h0));
      wr(DR, 32'h1234);
      frame;
      rd(DR);
      if (k == 0 || k == 2) len0 = len;
      if (k == 1) check(32'(len - len0), 32'd15);
      if (k == 2) check(spicc_peer_i.rx_word, 32'h1234);
      if (k == 3) check(32'(len - len0), 32'd5);
    end
    wr(spicc_pkg::A_CTRL0, 32'h040F);
    for (k = 0; k < 3; k++) begin
      lvl = (k == 0) ? 1 : (k == 1) ? 4 : 8;
      wr(C1, 32'(k) << spicc_pkg::RXTHR_LO | 32'(k) << spicc_pkg::TXTHR_LO);
      rd(IQ);
      for (j = 0; j < lvl - 1; j++) wr(DR, 32'(j));
      rd(IQ); check(32'(q[1]), 32'h0);
      wr(DR, 32'h7);
      rd(IQ); check(32'(q[1]), 32'h1);
      wr(spicc_pkg::A_MASK, 32'h2);
      rd(spicc_pkg::A_MASK); check(q, 32'h2);
      repeat (2) @(posedge pclk);
      check(32'(irq), 32'h1);
      wr(spicc_pkg::A_MASK, 32'h0);
      repeat (2) @(posedge pclk);
      check(32'(irq), 32'h0);
      wr(C1, EN | 32'(k) << spicc_pkg::RXTHR_LO);
      t = 0;
      do begin
        rd(spicc_pkg::A_STAT);
        t++;
      end while (!(q[0] === 1'b1 && q[4] === 1'b0) && t < 1000);
      if (t >= 1000) hang;
      wr(C1, 32'(k) << spicc_pkg::RXTHR_LO);
      rd(IQ); check(32'({q[3], q[0]}), 32'h3);
      rd(IQ); check(32'(q[3]), 32'h0);
      rd(DR);
      rd(IQ);
      rd(IQ); check(32'(q[0]), 32'h0);
      for (j = 1; j < lvl; j++) rd(DR);
    end
    wr(spicc_pkg::A_CTRL0, 32'h0407);
    for (k = 0; k < 2; k++) begin
      wr(DR, 32'h96);
      wr(C1, EN | 32'h4 | 32'(k) << spicc_pkg::GATE_B | 32'(k) << spicc_pkg::DLY_B);
      oe_seen <= 1'b0;
      @(posedge pclk);
      spicc_peer_i.xfer(8, 32'h3C, got);
      repeat (10) @(posedge pclk);
      check(32'(oe_seen), 32'(k == 0));
      check(32'({sclk_oe, mosi_oe}), 32'h0);
      if (k == 0) check(got, 32'h96);
      rd(DR); check(q, 32'h3C);
    end
    wrap_up;
  end
endmodule : spi_control_config_test
